// ---- cwfd_params.svh ----
`ifndef CWFD_PARAMS_SVH
`define CWFD_PARAMS_SVH
`define CWFD_CMD_CFG_WRITE   4'hB
`define CWFD_CMD_MEM_READ    4'h6
`define CWFD_CMD_MEM_RD_MULT 4'hC
`define CWFD_CMD_SPECIAL     4'h1
`define CWFD_SC_DEVICE       5'h1F
`define CWFD_SC_FUNCTION     3'h7
`define CWFD_TYPE0           2'h0
`define CWFD_TYPE1           2'h1
`define CWFD_BUS_LSB         16
`define CWFD_DEV_LSB         11
`define CWFD_FUN_LSB         8
`define CWFD_DEV_BIT0        11
`define CWFD_ZERO_ADDR       32'h0000_0000
`define CWFD_ZERO_CMD        4'h0
`define CWFD_TYPE_LSB        0
`define CWFD_REG_LSB         2
`define CWFD_IDSEL_W         21
`endif

// ---- cwfd_pkg.sv ----
package cwfd_pkg;
   typedef enum logic [1:0] {
      CWFD_IGNORE   = 2'h0,
      CWFD_TO_TYPE0 = 2'h1,
      CWFD_PASS_T1  = 2'h2,
      CWFD_SPECIAL  = 2'h3
   } cwfd_action_type;
endpackage : cwfd_pkg

// ---- cwfd_bus_range.sv ----
`timescale 1ns/100ps
`include "cwfd_params.svh"
// classify target bus against secondary and subordinate numbers
module cwfd_bus_range #(
   parameter int BUS_W = 8
) (
   input  wire logic [BUS_W-1:0] target_bus,
   input  wire logic [BUS_W-1:0] sec_bus,
   input  wire logic [BUS_W-1:0] sub_bus,
   output logic                  is_sec,
   output logic                  is_below
);
   if (BUS_W < 1 || BUS_W > 8) begin : g_bad_width
      $error("cwfd_bus_range: BUS_W must be 1..8");
   end
   // bus numbers strictly above secondary up to subordinate are behind us
   always_comb begin
      is_sec   = (target_bus == sec_bus);
      is_below = (target_bus > sec_bus) && (target_bus <= sub_bus);
   end
endmodule : cwfd_bus_range

// ---- cwfd_decode.sv ----
`timescale 1ns/100ps
`include "cwfd_params.svh"
// ========================================
module cwfd_decode (
   input  wire logic        CLK_SYS,
   input  wire logic        RST,
   input  wire logic        REQ_VALID,
   input  wire logic [3:0]  REQ_CMD,
   input  wire logic [31:0] REQ_ADDR,
   input  wire logic [7:0]  SEC_BUS,
   input  wire logic [7:0]  SUB_BUS,
   output logic             CLAIM,
   output logic             FWD_VALID,
   output logic [3:0]       FWD_CMD,
   output logic [31:0]      FWD_ADDR,
   output logic [1:0]       FWD_ACTION
);
   // ========================================
   // decode
   logic [7:0]                 tgt_bus;
   logic [4:0]                 tgt_dev;
   logic [2:0]                 tgt_fun;
   logic                       is_sec;
   logic                       is_below;
   logic                       is_cfg_t1;
   logic                       is_special;
   logic                       is_mrm;
   cwfd_pkg::cwfd_action_type  act;
   logic [3:0]                 nxt_cmd;
   logic [31:0]                nxt_addr;
   logic                       claim_ff;
   logic [3:0]                 cmd_ff;
   logic [31:0]                addr_ff;
   cwfd_pkg::cwfd_action_type  act_ff;
   logic [`CWFD_IDSEL_W-1:0]   idsel;
   logic [8:0]                 reg_field;
   logic                       is_mrd;
   logic                       nxt_claim;
   cwfd_pkg::cwfd_action_type  nxt_act;

   assign tgt_bus = REQ_ADDR[`CWFD_BUS_LSB +: 8];
   assign tgt_dev = REQ_ADDR[`CWFD_DEV_LSB +: 5];
   assign tgt_fun = REQ_ADDR[`CWFD_FUN_LSB +: 3];
   assign reg_field = REQ_ADDR[`CWFD_REG_LSB +: 9];

   // ========================================
   // type 0 select lines
   // one line per device number; numbers past the last line select nothing
   for (genvar i = 0; i < `CWFD_IDSEL_W; i++) begin : g_idsel
      assign idsel[i] = (tgt_dev == 5'(i));
   end

   cwfd_bus_range #(.BUS_W(8)) u_range (
      .target_bus (tgt_bus),
      .sec_bus    (SEC_BUS),
      .sub_bus    (SUB_BUS),
      .is_sec     (is_sec),
      .is_below   (is_below)
   );

   assign is_cfg_t1  = (REQ_CMD == `CWFD_CMD_CFG_WRITE) && (REQ_ADDR[`CWFD_TYPE_LSB +: 2] == `CWFD_TYPE1);
   assign is_special = is_cfg_t1 && (tgt_dev == `CWFD_SC_DEVICE) && (tgt_fun == `CWFD_SC_FUNCTION);
   assign is_mrm     = (REQ_CMD == `CWFD_CMD_MEM_RD_MULT);
   assign is_mrd     = (REQ_CMD == `CWFD_CMD_MEM_READ);

   // special cycle uses the data phase as message; address is not meaningful
   always_comb begin
      act      = cwfd_pkg::CWFD_IGNORE;
      nxt_cmd  = REQ_CMD;
      nxt_addr = REQ_ADDR;
      if (is_special) begin
         if (is_sec) begin
            act      = cwfd_pkg::CWFD_SPECIAL;
            nxt_cmd  = `CWFD_CMD_SPECIAL;
            nxt_addr = `CWFD_ZERO_ADDR;
         end else if (is_below) begin
            act = cwfd_pkg::CWFD_PASS_T1;
         end
      end else if (is_cfg_t1) begin
         if (is_sec) begin
            act      = cwfd_pkg::CWFD_TO_TYPE0;
            // one-hot IDSEL from device number, function/register kept, type 0
            nxt_addr = {idsel, reg_field, `CWFD_TYPE0};
         end else if (is_below) begin
            act = cwfd_pkg::CWFD_PASS_T1;
         end // else unclaimed
      end else if (is_mrd || is_mrm) begin
         // memory window decode lives elsewhere; both reads share one path
         // so the multiple form can never drift from the plain one
         act = cwfd_pkg::CWFD_PASS_T1;
      end
   end

   // ========================================
   // next values
   assign nxt_claim = REQ_VALID && (act != cwfd_pkg::CWFD_IGNORE);
   assign nxt_act   = REQ_VALID ? act : cwfd_pkg::CWFD_IGNORE;

   // ========================================
   // claim
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         claim_ff <= 1'h0;
      end else begin
         claim_ff <= nxt_claim;
      end
   end

   // ========================================
   // forwarded command and address
   // these follow the request every cycle to save a gate; only FWD_VALID makes them meaningful
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         cmd_ff <= `CWFD_ZERO_CMD;
      end else begin
         cmd_ff <= nxt_cmd;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         addr_ff <= `CWFD_ZERO_ADDR;
      end else begin
         addr_ff <= nxt_addr;
      end
   end

   // ========================================
   // action
   always_ff @(posedge CLK_SYS) begin
      if (RST) begin
         act_ff <= cwfd_pkg::CWFD_IGNORE;
      end else begin
         act_ff <= nxt_act;
      end
   end

   // ========================================
   // output pins
   assign CLAIM      = claim_ff;
   assign FWD_VALID  = claim_ff;
   assign FWD_CMD    = cmd_ff;
   assign FWD_ADDR   = addr_ff;
   assign FWD_ACTION = act_ff;

   // ========================================
   // checks
   type0_conv_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && !is_special && is_sec |=> CLAIM && FWD_ADDR[1:0] == `CWFD_TYPE0)
      else $error("type 0 conversion missing");
   type1_pass_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && !is_special && is_below |=> CLAIM && FWD_ADDR == $past(REQ_ADDR))
      else $error("type 1 pass changed address");
   unclaimed_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && !is_sec && !is_below |=> !CLAIM)
      else $error("foreign bus claimed");
   special_det_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && tgt_dev == `CWFD_SC_DEVICE && tgt_fun == `CWFD_SC_FUNCTION
      |=> FWD_ACTION != cwfd_pkg::CWFD_TO_TYPE0)
      else $error("special request converted to type 0");
   special_gen_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_special && is_sec |=> CLAIM && FWD_CMD == `CWFD_CMD_SPECIAL)
      else $error("special cycle not generated");
   special_pass_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_special && !is_sec
      |=> CLAIM == $past(is_below) && FWD_CMD == `CWFD_CMD_CFG_WRITE && FWD_ADDR == $past(REQ_ADDR))
      else $error("special request below mishandled");
   mrm_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && REQ_CMD == `CWFD_CMD_MEM_RD_MULT |=> CLAIM && FWD_CMD == `CWFD_CMD_MEM_RD_MULT)
      else $error("memory read multiple dropped");
   bus_cmp_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      is_below |-> tgt_bus > SEC_BUS && tgt_bus <= SUB_BUS)
      else $error("bus range compare wrong");
   idle_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      !REQ_VALID |=> !CLAIM)
      else $error("claim without request");
   idsel_line_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && !is_special && is_sec && tgt_dev < 5'(`CWFD_IDSEL_W)
      |=> (FWD_ADDR >> `CWFD_DEV_BIT0) == (32'h0000_0001 << $past(tgt_dev))
          && FWD_ADDR[`CWFD_DEV_BIT0-1:`CWFD_REG_LSB] == $past(reg_field))
      else $error("type 0 select line or register field wrong");
   type0_cmd_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && !is_special && is_sec
      |=> FWD_CMD == `CWFD_CMD_CFG_WRITE && FWD_ACTION == cwfd_pkg::CWFD_TO_TYPE0)
      else $error("type 0 conversion command wrong");
   type1_cmd_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_cfg_t1 && !is_special && is_below
      |=> FWD_CMD == `CWFD_CMD_CFG_WRITE && FWD_ACTION == cwfd_pkg::CWFD_PASS_T1)
      else $error("type 1 pass command wrong");
   special_addr_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_special && is_sec
      |=> FWD_ADDR == `CWFD_ZERO_ADDR && FWD_ACTION == cwfd_pkg::CWFD_SPECIAL)
      else $error("special cycle action or address wrong");
   special_drop_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && is_special && !is_sec && !is_below |=> FWD_ACTION == cwfd_pkg::CWFD_IGNORE)
      else $error("foreign special request acted on");
   mem_read_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && REQ_CMD == `CWFD_CMD_MEM_READ
      |=> CLAIM && FWD_CMD == `CWFD_CMD_MEM_READ && FWD_ACTION == cwfd_pkg::CWFD_PASS_T1)
      else $error("memory read not forwarded");
   other_cmd_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      REQ_VALID && !is_cfg_t1 && REQ_CMD != `CWFD_CMD_MEM_READ && REQ_CMD != `CWFD_CMD_MEM_RD_MULT |=> !CLAIM)
      else $error("unhandled command claimed");
   claim_act_a: assert property (@(posedge CLK_SYS) disable iff (RST)
      CLAIM == (FWD_ACTION != cwfd_pkg::CWFD_IGNORE) && FWD_VALID == CLAIM)
      else $error("claim and action disagree");
   reset_a: assert property (@(posedge CLK_SYS)
      RST |=> !CLAIM && FWD_ACTION == cwfd_pkg::CWFD_IGNORE && FWD_ADDR == `CWFD_ZERO_ADDR)
      else $error("outputs not cleared by reset");

   // ========================================
   // main scenarios
   cov_type0_c:   cover property (@(posedge CLK_SYS) disable iff (RST) FWD_ACTION == cwfd_pkg::CWFD_TO_TYPE0);
   cov_pass_c:    cover property (@(posedge CLK_SYS) disable iff (RST) FWD_ACTION == cwfd_pkg::CWFD_PASS_T1);
   cov_special_c: cover property (@(posedge CLK_SYS) disable iff (RST) FWD_ACTION == cwfd_pkg::CWFD_SPECIAL);
   cov_ignore_c:  cover property (@(posedge CLK_SYS) disable iff (RST) REQ_VALID && is_cfg_t1 ##1 !CLAIM);
   cov_mem_c:     cover property (@(posedge CLK_SYS) disable iff (RST) REQ_VALID && is_mrd ##1 CLAIM);
endmodule : cwfd_decode

// ---- cwfd_sec_sink.sv ----
`timescale 1ns/100ps
// ========================================
// secondary side sink: counts forwarded cycles
module cwfd_sec_sink (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        fwd_valid,
   output logic [7:0]       count_ff
);
   always_ff @(posedge clk) begin
      if (rst) count_ff <= 8'h00;
      else if (fwd_valid) count_ff <= count_ff + 8'h01;
   end
endmodule : cwfd_sec_sink

// ---- testbench.sv ----
`timescale 1ns/100ps
// ========================================
// bench: secondary 04h, subordinate 09h; t_bus_move then sets both to 10h
module testbench;
   logic        clk_sys = 1'h0;
   logic        rst = 1'h1;
   logic        req_valid = 1'h0;
   logic [7:0]  sec_bus = 8'h04;
   logic [7:0]  sub_bus = 8'h09;
   logic [3:0]  req_cmd = 4'h0;
   logic [31:0] req_addr = 32'h0;
   logic        claim, fwd_valid;
   logic [3:0]  fwd_cmd;
   logic [31:0] fwd_addr;
   logic [1:0]  fwd_action;
   logic [7:0]  sink_cnt;
   int          n_fail = 0;
   int          compares = 0;
   always #50 clk_sys = ~clk_sys;
   cwfd_decode u_cwfd_decode (.CLK_SYS(clk_sys), .RST(rst), .REQ_VALID(req_valid), .REQ_CMD(req_cmd),
      .REQ_ADDR(req_addr), .SEC_BUS(sec_bus), .SUB_BUS(sub_bus), .CLAIM(claim), .FWD_VALID(fwd_valid),
      .FWD_CMD(fwd_cmd), .FWD_ADDR(fwd_addr), .FWD_ACTION(fwd_action));
   cwfd_sec_sink u_cwfd_sec_sink (.clk(clk_sys), .rst(rst), .fwd_valid(fwd_valid), .count_ff(sink_cnt));
   function automatic logic [31:0] a1(logic [7:0] b, logic [4:0] d, logic [2:0] f);
      return {8'h00, b, d, f, 6'h08, 2'h1};
   endfunction : a1
   task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
      compares++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t decode mismatch %h", $time, seen);
      end
   endtask : chk
   // one request, answer sampled just after the next edge
   task automatic go(input logic [3:0] c, input logic [31:0] a);
      @(posedge clk_sys);
      req_cmd <= c;
      req_addr <= a;
      req_valid <= 1'h1;
      @(posedge clk_sys);
      req_valid <= 1'h0;
      #1;
   endtask : go
   task automatic fwd(input logic [1:0] act, input logic [3:0] c, input logic [31:0] a);
      chk({claim, fwd_valid, fwd_action, fwd_cmd, fwd_addr}, {2'h3, act, c, a});
   endtask : fwd
   task automatic t_sec_type0;
      go(4'hB, a1(8'h04, 5'h03, 3'h2));
      fwd(2'h1, 4'hB, 32'h0000_4000 | (a1(8'h04, 5'h03, 3'h2) & 32'h0000_07FC));
      go(4'hB, a1(8'h04, 5'h1F, 3'h6));
      fwd(2'h1, 4'hB, a1(8'h04, 5'h1F, 3'h6) & 32'h0000_07FC);
      go(4'hB, a1(8'h04, 5'h14, 3'h0));
      fwd(2'h1, 4'hB, 32'h8000_0000 | (a1(8'h04, 5'h14, 3'h0) & 32'h0000_07FC));
   endtask : t_sec_type0
   task automatic t_below_pass;
      go(4'hB, a1(8'h05, 5'h02, 3'h0));
      fwd(2'h2, 4'hB, a1(8'h05, 5'h02, 3'h0));
      go(4'hB, a1(8'h09, 5'h02, 3'h1));
      fwd(2'h2, 4'hB, a1(8'h09, 5'h02, 3'h1));
   endtask : t_below_pass
   task automatic t_ignore;
      go(4'hB, a1(8'h03, 5'h02, 3'h0));
      chk({claim, fwd_valid, fwd_action}, 40'h0);
      go(4'hB, a1(8'h0A, 5'h02, 3'h0));
      chk({claim, fwd_valid, fwd_action}, 40'h0);
      go(4'hB, a1(8'h04, 5'h02, 3'h0) & 32'hFFFF_FFFC);
      chk({claim, fwd_valid, fwd_action}, 40'h0);
   endtask : t_ignore
   task automatic t_special;
      go(4'hB, a1(8'h04, 5'h1F, 3'h7));
      fwd(2'h3, 4'h1, 32'h0);
      go(4'hB, a1(8'h09, 5'h1F, 3'h7));
      fwd(2'h2, 4'hB, a1(8'h09, 5'h1F, 3'h7));
      go(4'hB, a1(8'h0A, 5'h1F, 3'h7));
      chk({claim, fwd_valid, fwd_action}, 40'h0);
   endtask : t_special
   task automatic t_mrm;
      go(4'hC, 32'h1234_5670);
      fwd(2'h2, 4'hC, 32'h1234_5670);
      go(4'h6, 32'h1234_5670);
      fwd(2'h2, 4'h6, 32'h1234_5670);
      go(4'h7, 32'h1234_5670);
      chk({claim, fwd_valid, fwd_action}, 40'h0);
   endtask : t_mrm
   task automatic t_bus_move;
      @(posedge clk_sys);
      sec_bus <= 8'h10;
      sub_bus <= 8'h10;
      go(4'hB, a1(8'h10, 5'h00, 3'h0));
      fwd(2'h1, 4'hB, 32'h0000_0800 | (a1(8'h10, 5'h00, 3'h0) & 32'h0000_07FC));
      go(4'hB, a1(8'h09, 5'h02, 3'h0));
      chk({claim, fwd_valid, fwd_action}, 40'h0);
   endtask : t_bus_move
   task automatic tally_and_finish;
      if (n_fail == 0 && compares > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   initial begin
      repeat (6) @(posedge clk_sys);
      rst <= 1'h0;
      t_sec_type0();
      t_below_pass();
      t_ignore();
      t_special();
      t_mrm();
      t_bus_move();
      repeat (2) @(posedge clk_sys);
      #1;
      chk({32'h0, sink_cnt}, 40'hA);
      tally_and_finish();
   end
   initial begin
      repeat (2000) @(posedge clk_sys);
      n_fail++;
      tally_and_finish();
   end
endmodule : testbench
